// ==== rtl/xod_decoder.sv ====
// Behaviour
// RQ1 - Scaled byte follows locator 100, class not 11; code does this only with 32-bit addressing
// RQ2 - Middle bits feed register select and opcode extension
// RQ3 - Address size picks 16-bit or 32-bit table
// RQ4 - 16-bit class displacements, locator pairs, direct 110
// RQ5 - 16-bit frame-pointer forms use stack segment
// RQ6 - 32-bit base register, locator 101 direct d32
// RQ7 - 32-bit frame-pointer forms use stack segment
// RQ8 - Class 11 selects byte or full register
// RQ9 - Scaled byte: base 101 direct, 100/101 stack
// RQ10 - Scaled byte displacements; other bases data segment
// RQ11 - Multiplier codes scale index by 1,2,4,8
// RQ12 - Index 100 means none; nonzero scale undefined
// RQ13 - Direction bit swaps source and destination roles
// RQ14 - Sign-extend 8-bit immediate when extension bit set
// RQ15 - Upper condition bits select, low bit negates
// RQ16 - Eight condition selectors map to flag tests
// RQ17 - Control selector codes 000, 010, 011 only
// RQ18 - Debug selector: four addresses, status, control
// RQ19 - Test selector: 110 command, 111 data
// RQ20 - Width flag picks byte or full operand
// RQ21 - Sizes from default bit, prefixes toggle
// RQ22 - Segment selector codes 000..101; 110/111 unused
// RQ23 - Flag unused selector codes as invalid encoding
// RQ24 - Report displacement length and scaled-byte presence
`timescale 1ns/10ps
`include "xod_map.svh"

module xod_decoder (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic dec_valid,
  input wire logic [7:0] modrm,
  input wire logic [7:0] sib,
  input wire logic code_seg_default_32,
  input wire logic real_or_v86,
  input wire logic opsize_prefix,
  input wire logic addrsize_prefix,
  input wire logic width_flag,
  input wire logic direction_flag,
  input wire logic imm_ext_flag,
  input wire logic imm_is_8bit,
  input wire logic [3:0] cond_code,
  input wire logic flag_overflow,
  input wire logic flag_carry,
  input wire logic flag_zero,
  input wire logic flag_sign,
  input wire logic flag_parity,
  input wire xod_pkg::xod_spec_class_t spec_class,
  input wire logic [2:0] spec_sel,
  input wire logic seg_sel_used,
  input wire logic [2:0] segment_selector_wide,
  output logic out_valid,
  output logic addr32,
  output logic op32,
  output logic [2:0] reg_sel,
  output logic reg_high_byte,
  output logic [2:0] opcode_ext,
  output logic rm_is_reg,
  output logic [2:0] rm_reg_sel,
  output logic rm_high_byte,
  output logic base_valid,
  output logic [2:0] base_reg,
  output logic index_valid,
  output logic [2:0] index_reg,
  output logic [1:0] scale,
  output logic [2:0] disp_bytes,
  output logic sib_follows,
  output xod_pkg::xod_seg_t ea_seg,
  output logic ea_undefined,
  output logic dst_is_reg_field,
  output logic [2:0] operand_bytes,
  output logic imm_sign_extend,
  output xod_pkg::xod_cond_t cond_sel,
  output logic cond_negate,
  output logic cond_true,
  output xod_pkg::xod_spec_t spec_reg,
  output xod_pkg::xod_seg_t seg_sel,
  output logic invalid_encoding
);
  import xod_pkg::*;

  // ----------------------------------------------------------------
  // Effective-address decode
  // ----------------------------------------------------------------
  logic addr32_w;
  logic op32_w;
  logic ea_rm_is_reg;
  logic ea_sib_follows;
  logic ea_base_valid;
  logic [2:0] ea_base_reg;
  logic ea_index_valid;
  logic [2:0] ea_index_reg;
  logic [1:0] ea_scale;
  logic [2:0] ea_disp_bytes;
  logic ea_undef_w;
  xod_seg_t ea_seg_w;

  // Real and virtual-8086 modes force the 16-bit default before toggling
  assign addr32_w = (code_seg_default_32 & ~real_or_v86) ^ addrsize_prefix; // [RQ21]
  assign op32_w = (code_seg_default_32 & ~real_or_v86) ^ opsize_prefix; // [RQ21]

  xod_ea_decode u_ea (
    .addr32(addr32_w), // [RQ3]
    .modrm(modrm),
    .sib(sib),
    .rm_is_reg(ea_rm_is_reg),
    .sib_follows(ea_sib_follows),
    .base_valid(ea_base_valid),
    .base_reg(ea_base_reg),
    .index_valid(ea_index_valid),
    .index_reg(ea_index_reg),
    .scale(ea_scale),
    .disp_bytes(ea_disp_bytes),
    .ea_undefined(ea_undef_w),
    .ea_seg(ea_seg_w)
  );

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  xod_dec_t dec_r;
  xod_dec_t dec_nxt;
  logic [2:0] mid_bits;
  logic [2:0] loc_bits;
  logic cond_raw;
  logic spec_bad;
  logic seg_bad;

  assign mid_bits = modrm[`XOD_MID_MSB:`XOD_MID_LSB];
  assign loc_bits = modrm[`XOD_LOC_MSB:`XOD_LOC_LSB];

  // Flag test per selector; negation applied afterwards
  always_comb begin
    case (xod_cond_t'(cond_code[3:1])) // [RQ15]
      xod_cc_overflow: cond_raw = flag_overflow; // [RQ16]
      xod_cc_below: cond_raw = flag_carry;
      xod_cc_zero: cond_raw = flag_zero;
      xod_cc_below_eq: cond_raw = flag_carry | flag_zero;
      xod_cc_sign: cond_raw = flag_sign;
      xod_cc_parity: cond_raw = flag_parity;
      xod_cc_less: cond_raw = flag_sign ^ flag_overflow;
      xod_cc_less_eq: cond_raw = flag_zero | (flag_sign ^ flag_overflow);
      default: cond_raw = 1'b0;
    endcase
  end

  // Special register selection and reserved-code detection
  xod_spec_t spec_w;
  always_comb begin
    spec_w = xod_sp_none;
    spec_bad = 1'b0;
    case (spec_class)
      xod_sc_control: begin
        case (spec_sel) // [RQ17]
          `XOD_CTL_0: spec_w = xod_sp_machine_control_0;
          `XOD_CTL_2: spec_w = xod_sp_machine_control_2;
          `XOD_CTL_3: spec_w = xod_sp_machine_control_3;
          default: spec_bad = 1'b1; // [RQ23]
        endcase
      end
      xod_sc_debug: begin
        if (spec_sel <= `XOD_DBG_ADDR_LAST) begin
          spec_w = xod_spec_t'(4'(xod_sp_bp_addr_0) + {2'h0, spec_sel[1:0]}); // [RQ18]
        end else if (spec_sel == `XOD_DBG_STATUS) begin
          spec_w = xod_sp_breakpoint_status; // [RQ18]
        end else if (spec_sel == `XOD_DBG_CONTROL) begin
          spec_w = xod_sp_breakpoint_control;
        end else begin
          spec_bad = 1'b1; // [RQ23]
        end
      end
      xod_sc_test: begin
        case (spec_sel) // [RQ19]
          `XOD_TST_COMMAND: spec_w = xod_sp_tlb_test_command;
          `XOD_TST_DATA: spec_w = xod_sp_tlb_test_data;
          default: spec_bad = 1'b1; // [RQ23]
        endcase
      end
      default: spec_w = xod_sp_none;
    endcase
  end

  // Codes past the sixth segment are not to be used
  assign seg_bad = seg_sel_used && (segment_selector_wide > `XOD_SEG_LAST_CODE); // [RQ22]

  always_comb begin
    dec_nxt = dec_r;
    dec_nxt.valid = dec_valid;
    if (dec_valid) begin
      dec_nxt.addr32 = addr32_w;
      dec_nxt.op32 = op32_w;
      // Byte operands: codes 4..7 are the high halves of A, C, D, B
      if (width_flag) begin
        dec_nxt.reg_sel = mid_bits; // [RQ2]
        dec_nxt.reg_high_byte = 1'b0;
        dec_nxt.rm_reg_sel = loc_bits; // [RQ8]
        dec_nxt.rm_high_byte = 1'b0;
      end else begin
        dec_nxt.reg_sel = {1'b0, mid_bits[1:0]}; // [RQ20]
        dec_nxt.reg_high_byte = mid_bits[2];
        dec_nxt.rm_reg_sel = {1'b0, loc_bits[1:0]}; // [RQ8]
        dec_nxt.rm_high_byte = loc_bits[2];
      end
      // Same bits also go out untouched for opcode-group decode
      dec_nxt.opcode_ext = mid_bits; // [RQ2]
      dec_nxt.rm_is_reg = ea_rm_is_reg;
      dec_nxt.base_valid = ea_base_valid;
      dec_nxt.base_reg = ea_base_reg;
      dec_nxt.index_valid = ea_index_valid;
      dec_nxt.index_reg = ea_index_reg;
      dec_nxt.scale = ea_scale; // [RQ11]
      dec_nxt.disp_bytes = ea_disp_bytes; // [RQ24]
      dec_nxt.sib_follows = ea_sib_follows; // [RQ24]
      dec_nxt.ea_seg = ea_seg_w;
      dec_nxt.ea_undefined = ea_undef_w; // [RQ12]
      dec_nxt.dst_is_reg_field = direction_flag; // [RQ13]
      if (!width_flag) begin
        dec_nxt.operand_bytes = `XOD_BYTES_1; // [RQ20]
      end else if (op32_w) begin
        dec_nxt.operand_bytes = `XOD_BYTES_4;
      end else begin
        dec_nxt.operand_bytes = `XOD_BYTES_2;
      end
      // Only an 8-bit immediate headed for a wider target is extended
      dec_nxt.imm_sign_extend = imm_ext_flag & imm_is_8bit & width_flag; // [RQ14]
      dec_nxt.cond_sel = xod_cond_t'(cond_code[3:1]); // [RQ15]
      dec_nxt.cond_negate = cond_code[0];
      dec_nxt.cond_true = cond_raw ^ cond_code[0]; // [RQ15]
      dec_nxt.spec_reg = spec_w;
      // Reserved segment codes map to data while seg_sel_used is set; otherwise they pass through
      dec_nxt.seg_sel = seg_bad ? xod_seg_data : xod_seg_t'(segment_selector_wide);
      dec_nxt.invalid_encoding = spec_bad | seg_bad; // [RQ23]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dec_r <= '0;
    end else begin
      dec_r <= dec_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign out_valid = dec_r.valid;
  assign addr32 = dec_r.addr32;
  assign op32 = dec_r.op32;
  assign reg_sel = dec_r.reg_sel;
  assign reg_high_byte = dec_r.reg_high_byte;
  assign opcode_ext = dec_r.opcode_ext;
  assign rm_is_reg = dec_r.rm_is_reg;
  assign rm_reg_sel = dec_r.rm_reg_sel;
  assign rm_high_byte = dec_r.rm_high_byte;
  assign base_valid = dec_r.base_valid;
  assign base_reg = dec_r.base_reg;
  assign index_valid = dec_r.index_valid;
  assign index_reg = dec_r.index_reg;
  assign scale = dec_r.scale;
  assign disp_bytes = dec_r.disp_bytes;
  assign sib_follows = dec_r.sib_follows;
  assign ea_seg = dec_r.ea_seg;
  assign ea_undefined = dec_r.ea_undefined;
  assign dst_is_reg_field = dec_r.dst_is_reg_field;
  assign operand_bytes = dec_r.operand_bytes;
  assign imm_sign_extend = dec_r.imm_sign_extend;
  assign cond_sel = dec_r.cond_sel;
  assign cond_negate = dec_r.cond_negate;
  assign cond_true = dec_r.cond_true;
  assign spec_reg = dec_r.spec_reg;
  assign seg_sel = dec_r.seg_sel;
  assign invalid_encoding = dec_r.invalid_encoding;

endmodule

// ==== rtl/xod_map.svh ====
`ifndef XOD_MAP_SVH
`define XOD_MAP_SVH

// ----------------------------------------------------------------
// Field positions within the addressing and scaled-address bytes
// ----------------------------------------------------------------
`define XOD_CLS_MSB 7
`define XOD_CLS_LSB 6
`define XOD_MID_MSB 5
`define XOD_MID_LSB 3
`define XOD_LOC_MSB 2
`define XOD_LOC_LSB 0

// ----------------------------------------------------------------
// Addressing class and locator codes
// ----------------------------------------------------------------
`define XOD_CLS_NODISP 2'h0
`define XOD_CLS_DISP8 2'h1
`define XOD_CLS_DISPW 2'h2
`define XOD_CLS_REG 2'h3
`define XOD_LOC_SIB 3'h4
`define XOD_LOC_DIRECT32 3'h5
`define XOD_LOC_DIRECT16 3'h6
`define XOD_IDX_NONE 3'h4
`define XOD_SCALE_X1 2'h0

// ----------------------------------------------------------------
// General register numbers
// ----------------------------------------------------------------
`define XOD_GR_A 3'h0
`define XOD_GR_B 3'h3
`define XOD_GR_SP 3'h4
`define XOD_GR_BP 3'h5
`define XOD_GR_SI 3'h6
`define XOD_GR_DI 3'h7

// ----------------------------------------------------------------
// Byte counts
// ----------------------------------------------------------------
`define XOD_BYTES_0 3'h0
`define XOD_BYTES_1 3'h1
`define XOD_BYTES_2 3'h2
`define XOD_BYTES_4 3'h4

// ----------------------------------------------------------------
// Selector codes
// ----------------------------------------------------------------
`define XOD_SEG_LAST_CODE 3'h5
`define XOD_CTL_0 3'h0
`define XOD_CTL_2 3'h2
`define XOD_CTL_3 3'h3
`define XOD_DBG_ADDR_LAST 3'h3
`define XOD_DBG_STATUS 3'h6
`define XOD_DBG_CONTROL 3'h7
`define XOD_TST_COMMAND 3'h6
`define XOD_TST_DATA 3'h7

`endif

// ==== rtl/xod_pkg.sv ====
package xod_pkg;

  typedef enum logic [2:0] {
    xod_seg_extra = 3'h0,
    xod_seg_code = 3'h1,
    xod_seg_stack = 3'h2,
    xod_seg_data = 3'h3,
    xod_seg_fourth = 3'h4,
    xod_seg_sixth = 3'h5
  } xod_seg_t;

  typedef enum logic [2:0] {
    xod_cc_overflow = 3'h0,
    xod_cc_below = 3'h1,
    xod_cc_zero = 3'h2,
    xod_cc_below_eq = 3'h3,
    xod_cc_sign = 3'h4,
    xod_cc_parity = 3'h5,
    xod_cc_less = 3'h6,
    xod_cc_less_eq = 3'h7
  } xod_cond_t;

  typedef enum logic [1:0] {
    xod_sc_none = 2'h0,
    xod_sc_control = 2'h1,
    xod_sc_debug = 2'h2,
    xod_sc_test = 2'h3
  } xod_spec_class_t;

  typedef enum logic [3:0] {
    xod_sp_none = 4'h0,
    xod_sp_machine_control_0 = 4'h1,
    xod_sp_machine_control_2 = 4'h2,
    xod_sp_machine_control_3 = 4'h3,
    xod_sp_bp_addr_0 = 4'h4,
    xod_sp_bp_addr_1 = 4'h5,
    xod_sp_bp_addr_2 = 4'h6,
    xod_sp_bp_addr_3 = 4'h7,
    xod_sp_breakpoint_status = 4'h8,
    xod_sp_breakpoint_control = 4'h9,
    xod_sp_tlb_test_command = 4'ha,
    xod_sp_tlb_test_data = 4'hb
  } xod_spec_t;

  typedef struct packed {
    logic valid;
    logic addr32;
    logic op32;
    logic [2:0] reg_sel;
    logic reg_high_byte;
    logic [2:0] opcode_ext;
    logic rm_is_reg;
    logic [2:0] rm_reg_sel;
    logic rm_high_byte;
    logic base_valid;
    logic [2:0] base_reg;
    logic index_valid;
    logic [2:0] index_reg;
    logic [1:0] scale;
    logic [2:0] disp_bytes;
    logic sib_follows;
    xod_seg_t ea_seg;
    logic ea_undefined;
    logic dst_is_reg_field;
    logic [2:0] operand_bytes;
    logic imm_sign_extend;
    xod_cond_t cond_sel;
    logic cond_negate;
    logic cond_true;
    xod_spec_t spec_reg;
    xod_seg_t seg_sel;
    logic invalid_encoding;
  } xod_dec_t;

endpackage

// ==== rtl/xod_ea_decode.sv ====
`timescale 1ns/10ps
`include "xod_map.svh"

module xod_ea_decode (
  input wire logic addr32,
  input wire logic [7:0] modrm,
  input wire logic [7:0] sib,
  output logic rm_is_reg,
  output logic sib_follows,
  output logic base_valid,
  output logic [2:0] base_reg,
  output logic index_valid,
  output logic [2:0] index_reg,
  output logic [1:0] scale,
  output logic [2:0] disp_bytes,
  output logic ea_undefined,
  output xod_pkg::xod_seg_t ea_seg
);
  import xod_pkg::*;

  logic [1:0] cls;
  logic [2:0] loc;
  logic [1:0] ss;
  logic [2:0] idx;
  logic [2:0] bse;

  assign cls = modrm[`XOD_CLS_MSB:`XOD_CLS_LSB];
  assign loc = modrm[`XOD_LOC_MSB:`XOD_LOC_LSB];
  assign ss = sib[`XOD_CLS_MSB:`XOD_CLS_LSB];
  assign idx = sib[`XOD_MID_MSB:`XOD_MID_LSB];
  assign bse = sib[`XOD_LOC_MSB:`XOD_LOC_LSB];

  always_comb begin
    rm_is_reg = 1'b0;
    sib_follows = 1'b0;
    base_valid = 1'b1;
    base_reg = loc;
    index_valid = 1'b0;
    index_reg = `XOD_GR_A;
    scale = `XOD_SCALE_X1;
    disp_bytes = `XOD_BYTES_0;
    ea_undefined = 1'b0;
    ea_seg = xod_seg_data;
    if (cls == `XOD_CLS_REG) begin
      rm_is_reg = 1'b1; // [RQ8]
      base_valid = 1'b0;
    end else if (!addr32) begin
      // 16-bit table: pairs for locators 0..3, single pointers above
      case (loc)
        3'h0, 3'h1: base_reg = `XOD_GR_B; // [RQ4]
        3'h2, 3'h3: base_reg = `XOD_GR_BP;
        3'h4: base_reg = `XOD_GR_SI;
        3'h5: base_reg = `XOD_GR_DI;
        3'h6: base_reg = `XOD_GR_BP;
        default: base_reg = `XOD_GR_B;
      endcase
      index_valid = (loc < 3'h4);
      index_reg = loc[0] ? `XOD_GR_DI : `XOD_GR_SI;
      case (cls)
        `XOD_CLS_DISP8: disp_bytes = `XOD_BYTES_1; // [RQ4]
        `XOD_CLS_DISPW: disp_bytes = `XOD_BYTES_2;
        default: begin
          if (loc == `XOD_LOC_DIRECT16) begin
            base_valid = 1'b0; // [RQ4]
            disp_bytes = `XOD_BYTES_2;
          end
        end
      endcase
      if (base_valid && base_reg == `XOD_GR_BP) begin
        ea_seg = xod_seg_stack; // [RQ5]
      end
    end else if (loc == `XOD_LOC_SIB) begin
      sib_follows = 1'b1; // [RQ1]
      base_reg = bse;
      index_valid = (idx != `XOD_IDX_NONE); // [RQ12]
      index_reg = idx; // [RQ11]
      scale = ss; // [RQ11]
      ea_undefined = !index_valid && (ss != `XOD_SCALE_X1); // [RQ12]
      case (cls)
        `XOD_CLS_DISP8: disp_bytes = `XOD_BYTES_1; // [RQ10]
        `XOD_CLS_DISPW: disp_bytes = `XOD_BYTES_4;
        default: begin
          if (bse == `XOD_LOC_DIRECT32) begin
            base_valid = 1'b0; // [RQ9]
            disp_bytes = `XOD_BYTES_4;
          end
        end
      endcase
      if (base_valid && (bse == `XOD_GR_SP || bse == `XOD_GR_BP)) begin
        ea_seg = xod_seg_stack; // [RQ9]
      end
    end else begin
      case (cls)
        `XOD_CLS_DISP8: disp_bytes = `XOD_BYTES_1; // [RQ6]
        `XOD_CLS_DISPW: disp_bytes = `XOD_BYTES_4;
        default: begin
          if (loc == `XOD_LOC_DIRECT32) begin
            base_valid = 1'b0; // [RQ6]
            disp_bytes = `XOD_BYTES_4;
          end
        end
      endcase
      if (base_valid && loc == `XOD_GR_BP) begin
        ea_seg = xod_seg_stack; // [RQ7]
      end
    end
  end

endmodule

// ==== test/xod_sva.sv ====
`timescale 1ns/10ps

module xod_sva (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic dec_valid,
  input wire logic [7:0] modrm,
  input wire logic code_seg_default_32,
  input wire logic real_or_v86,
  input wire logic opsize_prefix,
  input wire logic addrsize_prefix,
  input wire logic width_flag,
  input wire logic direction_flag,
  input wire logic imm_ext_flag,
  input wire logic imm_is_8bit,
  input wire logic [3:0] cond_code,
  input wire logic out_valid,
  input wire logic addr32,
  input wire logic op32,
  input wire logic [2:0] opcode_ext,
  input wire logic rm_is_reg,
  input wire logic [2:0] disp_bytes,
  input wire logic sib_follows,
  input wire logic dst_is_reg_field,
  input wire logic imm_sign_extend,
  input wire xod_pkg::xod_cond_t cond_sel,
  input wire logic cond_negate,
  input wire logic invalid_encoding
);
  import xod_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  wire logic [1:0] cls_w = modrm[7:6];
  wire logic [2:0] loc_w = modrm[2:0];
  wire logic [2:0] mid_w = modrm[5:3];
  wire logic [2:0] csel_w = cond_code[3:1];
  wire logic neg_w = cond_code[0];

  // ----------------------------------------------------------------
  // Decode relations, one edge after the take
  // ----------------------------------------------------------------
  chk_sib_expect: assert property (
    out_valid |-> sib_follows == (addr32 && $past(loc_w) == 3'h4 && $past(cls_w) != 2'h3))
    else $error("scaled byte flag wrong");
  chk_mid_routed: assert property (dec_valid |=> opcode_ext == $past(mid_w))
    else $error("middle bits not routed");
  chk_addr_size: assert property (
    out_valid |-> addr32 == (($past(code_seg_default_32) && !$past(real_or_v86))
    ^ $past(addrsize_prefix))) else $error("address size wrong");
  chk_op_size: assert property (
    out_valid |-> op32 == (($past(code_seg_default_32) && !$past(real_or_v86))
    ^ $past(opsize_prefix))) else $error("operand size wrong");
  chk_reg_class: assert property (dec_valid ##1 out_valid |-> rm_is_reg == ($past(cls_w) == 2'h3))
    else $error("register class wrong");
  chk_wide_disp: assert property (
    out_valid && $past(cls_w) == 2'h2 |-> disp_bytes == (addr32 ? 3'h4 : 3'h2))
    else $error("wide displacement length wrong");
  chk_byte_disp: assert property (dec_valid && cls_w == 2'h1 |=> disp_bytes == 3'h1)
    else $error("byte displacement length wrong");
  chk_dir_roles: assert property (out_valid |-> dst_is_reg_field == $past(direction_flag))
    else $error("direction not reported");
  chk_cond_split: assert property (
    out_valid |-> cond_sel == $past(csel_w) && cond_negate == $past(neg_w))
    else $error("condition split wrong");
  chk_imm_extend: assert property (
    out_valid |-> imm_sign_extend == ($past(imm_ext_flag) && $past(imm_is_8bit)
    && $past(width_flag))) else $error("sign extension wrong");

  cov_sib: cover property (out_valid && sib_follows);
  cov_reg: cover property (out_valid && rm_is_reg);
  cov_bad: cover property (out_valid && invalid_encoding);
endmodule

bind xod_decoder xod_sva u_sva (
  .clk(clk), .sys_rst(sys_rst), .dec_valid(dec_valid), .modrm(modrm),
  .code_seg_default_32(code_seg_default_32), .real_or_v86(real_or_v86),
  .opsize_prefix(opsize_prefix), .addrsize_prefix(addrsize_prefix),
  .width_flag(width_flag), .direction_flag(direction_flag), .imm_ext_flag(imm_ext_flag),
  .imm_is_8bit(imm_is_8bit), .cond_code(cond_code), .out_valid(out_valid),
  .addr32(addr32), .op32(op32), .opcode_ext(opcode_ext), .rm_is_reg(rm_is_reg),
  .disp_bytes(disp_bytes), .sib_follows(sib_follows), .dst_is_reg_field(dst_is_reg_field),
  .imm_sign_extend(imm_sign_extend), .cond_sel(cond_sel), .cond_negate(cond_negate),
  .invalid_encoding(invalid_encoding)
);

// ==== test/xod_fetch.sv ====
`timescale 1ns/10ps

module xod_fetch (
  input wire logic clk,
  output logic dec_valid,
  output logic [7:0] modrm,
  output logic [7:0] sib
);
  initial begin
    dec_valid = 1'b0;
    modrm = 8'h00;
    sib = 8'h00;
  end

  // ----------------------------------------------------------------
  // One addressing request, held until the taking edge
  // ----------------------------------------------------------------
  task automatic issue(input logic [7:0] m, input logic [7:0] s, input logic bad, input int gap);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    #1;
    dec_valid = 1'b1;
    modrm = m;
    // Software leaves the multiplier at 00 with no index unless told to break it
    sib = (!bad && s[5:3] == 3'h4) ? {2'h0, s[5:0]} : s;
    @(posedge clk);
    #1;
    dec_valid = 1'b0;
    // Released bytes carry junk so a stale value cannot pass for a held one
    modrm = ~m;
    sib = ~s;
  endtask
endmodule

// ==== test/testbench.sv ====
`timescale 1ns/10ps

`define CK(g, w) begin \
  checks++; \
  if ((g) !== (w)) begin \
    num_errors++; \
    $display("unexpected t=%0t got %0h want %0h", $time, (g), (w)); \
  end \
end

module testbench;
  import xod_pkg::*;
  logic clk, sys_rst, dec_valid, code_seg_default_32, real_or_v86, opsize_prefix;
  logic addrsize_prefix, width_flag, direction_flag, imm_ext_flag, imm_is_8bit;
  logic flag_overflow, flag_carry, flag_zero, flag_sign, flag_parity, seg_sel_used;
  logic [7:0] modrm, sib;
  logic [3:0] cond_code;
  logic [2:0] spec_sel, segment_selector_wide;
  xod_spec_class_t spec_class;
  logic out_valid, addr32, op32, reg_high_byte, rm_is_reg, rm_high_byte, base_valid;
  logic index_valid, sib_follows, ea_undefined, dst_is_reg_field, imm_sign_extend;
  logic cond_negate, cond_true, invalid_encoding;
  logic [2:0] reg_sel, opcode_ext, rm_reg_sel, base_reg, index_reg, disp_bytes, operand_bytes;
  logic [1:0] scale;
  xod_seg_t ea_seg, seg_sel;
  xod_cond_t cond_sel;
  xod_spec_t spec_reg;
  int num_errors = 0;
  int checks = 0;

  xod_decoder uut (.*);
  xod_fetch fetch (.clk(clk), .dec_valid(dec_valid), .modrm(modrm), .sib(sib));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic final_report();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic sz(input logic a, input logic o);
    code_seg_default_32 = 1'b1;
    real_or_v86 = 1'b0;
    addrsize_prefix = !a;
    opsize_prefix = !o;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_sizes();
    for (int i = 0; i < 16; i++) begin
      {code_seg_default_32, real_or_v86, opsize_prefix, addrsize_prefix} = i[3:0];
      fetch.issue(8'hc0, 8'h00, 1'b0, i % 3);
      `CK(addr32, (i[3] & ~i[2]) ^ i[0])
      `CK(op32, (i[3] & ~i[2]) ^ i[1])
    end
    // Idle cycles must leave the last answer standing
    #30;
    `CK({out_valid, addr32, op32}, 3'h3)
  endtask

  task automatic t_ea16();
    logic bp;
    logic [2:0] b16 [8] = '{3'h3, 3'h3, 3'h5, 3'h5, 3'h6, 3'h7, 3'h5, 3'h3};
    sz(1'b0, 1'b0);
    for (int c = 0; c < 3; c++) for (int l = 0; l < 8; l++) begin
      fetch.issue({c[1:0], 3'h2, l[2:0]}, 8'h00, 1'b0, 0);
      bp = (l == 2 || l == 3 || (l == 6 && c != 0));
      `CK(ea_seg, bp ? xod_seg_stack : xod_seg_data)
      `CK(disp_bytes, c == 1 ? 3'h1 : (c == 2 || l == 6) ? 3'h2 : 3'h0)
      `CK(base_valid, !(c == 0 && l == 6))
      if (!(c == 0 && l == 6)) `CK(base_reg, b16[l])
      `CK(index_valid, l < 4)
      if (l < 4) `CK(index_reg, {2'h3, l[0]})
      `CK(sib_follows, 1'b0)
    end
  endtask

  task automatic t_ea32();
    logic dir;
    sz(1'b1, 1'b1);
    for (int c = 0; c < 3; c++) for (int l = 0; l < 8; l++) if (l != 4) begin
      fetch.issue({c[1:0], 3'h5, l[2:0]}, 8'h24, 1'b0, 0);
      dir = (c == 0 && l == 5);
      `CK(base_valid, !dir)
      if (!dir) `CK(base_reg, l[2:0])
      `CK(disp_bytes, c == 1 ? 3'h1 : (c == 2 || dir) ? 3'h4 : 3'h0)
      `CK(ea_seg, (l == 5 && c != 0) ? xod_seg_stack : xod_seg_data)
      `CK({sib_follows, index_valid}, 2'h0)
    end
  endtask

  task automatic t_sib();
    logic [2:0] ix;
    logic [1:0] sc;
    logic nb;
    sz(1'b1, 1'b0);
    for (int c = 0; c < 3; c++) for (int b = 0; b < 8; b++) begin
      ix = 3'(7 - b);
      sc = 2'(b + c);
      fetch.issue({c[1:0], 3'h1, 3'h4}, {sc, ix, b[2:0]}, 1'b1, 0);
      nb = (c == 0 && b == 5);
      `CK(sib_follows, 1'b1)
      `CK(base_valid, !nb)
      if (!nb) `CK(base_reg, b[2:0])
      `CK(disp_bytes, c == 1 ? 3'h1 : (c == 2 || nb) ? 3'h4 : 3'h0)
      `CK(ea_seg, (b == 4 || (b == 5 && c != 0)) ? xod_seg_stack : xod_seg_data)
      `CK(scale, sc)
      if (ix != 3'h4) `CK(index_reg, ix)
      `CK(index_valid, ix != 3'h4)
      `CK(ea_undefined, ix == 3'h4 && sc != 2'h0)
    end
  endtask

  task automatic t_reg();
    for (int i = 0; i < 32; i++) begin
      width_flag = i[3];
      opsize_prefix = i[4];
      fetch.issue({2'h3, ~i[2:0], i[2:0]}, 8'h00, 1'b0, 0);
      `CK({rm_is_reg, sib_follows, base_valid, disp_bytes}, 6'h20)
      `CK(rm_reg_sel, i[3] ? i[2:0] : {1'b0, i[1:0]})
      `CK(rm_high_byte, !i[3] && i[2])
      `CK(reg_sel, i[3] ? ~i[2:0] : {1'b0, ~i[1:0]})
      `CK(reg_high_byte, !i[3] && !i[2])
      `CK(opcode_ext, ~i[2:0])
      `CK(operand_bytes, !i[3] ? 3'h1 : i[4] ? 3'h2 : 3'h4)
    end
  endtask

  task automatic t_cond();
    logic [7:0] f;
    for (int i = 0; i < 256; i++) begin
      cond_code = i[3:0];
      {flag_overflow, flag_carry, flag_zero, flag_sign} = i[7:4];
      flag_parity = i[4] ^ i[1];
      {direction_flag, imm_ext_flag, imm_is_8bit, width_flag} = i[7:4] ^ i[3:0];
      fetch.issue(8'hc1, 8'h00, 1'b0, 0);
      f = {(flag_sign ^ flag_overflow) | flag_zero, flag_sign ^ flag_overflow, flag_parity,
        flag_sign, flag_carry | flag_zero, flag_zero, flag_carry, flag_overflow};
      `CK(cond_sel, i[3:1])
      `CK(cond_negate, i[0])
      `CK(cond_true, f[i[3:1]] ^ i[0])
      `CK(dst_is_reg_field, direction_flag)
      `CK(imm_sign_extend, imm_ext_flag & imm_is_8bit & width_flag)
    end
  endtask

  task automatic t_spec();
    xod_spec_t e;
    logic [2:0] s;
    for (int i = 0; i < 32; i++) begin
      spec_class = xod_spec_class_t'(i[4:3]);
      spec_sel = i[2:0];
      s = i[2:0];
      fetch.issue(8'hc0, 8'h00, 1'b0, 0);
      case (i[4:3])
        2'h1: e = s == 0 ? xod_sp_machine_control_0 : s == 2 ? xod_sp_machine_control_2 :
          s == 3 ? xod_sp_machine_control_3 : xod_sp_none;
        2'h2: e = s < 4 ? xod_spec_t'(4'(s) + 4'h4) : s == 6 ? xod_sp_breakpoint_status :
          s == 7 ? xod_sp_breakpoint_control : xod_sp_none;
        2'h3: e = s == 6 ? xod_sp_tlb_test_command : s == 7 ? xod_sp_tlb_test_data : xod_sp_none;
        default: e = xod_sp_none;
      endcase
      `CK(spec_reg, e)
      `CK(invalid_encoding, i[4:3] != 2'h0 && e == xod_sp_none)
    end
    spec_class = xod_sc_none;
    seg_sel_used = 1'b1;
    for (int g = 0; g < 8; g++) begin
      segment_selector_wide = g[2:0];
      fetch.issue(8'hc0, 8'h00, 1'b0, 0);
      `CK(invalid_encoding, g > 5)
      `CK(seg_sel, g > 5 ? xod_seg_data : xod_seg_t'(g[2:0]))
    end
    seg_sel_used = 1'b0;
  endtask

  initial begin
    #200000;
    num_errors++;
    final_report();
  end

  initial begin
    sys_rst = 1'b1;
    {code_seg_default_32, real_or_v86, opsize_prefix, addrsize_prefix, width_flag} = '0;
    {direction_flag, imm_ext_flag, imm_is_8bit, seg_sel_used} = '0;
    {flag_overflow, flag_carry, flag_zero, flag_sign, flag_parity} = '0;
    cond_code = 4'h0;
    spec_sel = 3'h0;
    segment_selector_wide = 3'h0;
    spec_class = xod_sc_none;
    repeat (20) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    t_sizes();
    t_ea16();
    t_ea32();
    t_sib();
    t_reg();
    t_cond();
    t_spec();
    final_report();
  end
endmodule
